// file: src/rate_filter_pkg.sv
package rate_filter_pkg;

  // Register byte offsets
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] RATE_CFG_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] RESULT_OFFSET = 4'hc;

  // Field positions
  localparam int RATE_LSB = 0;
  localparam int FILTER_BIT = 4;
  localparam int CLK_SEL_BIT = 5;
  localparam int CMD_RESET_BIT = 0;

  // Reset values
  localparam logic [7:0] RATE_CFG_RESET = 8'h00;

  // Timing counts
  localparam int MOD_DIV = 16;
  localparam int SINC3_WARMUP = 3;

  // Widths
  localparam int OSR_W = 17;
  localparam int ACC_W = 3 * OSR_W + 1;
  localparam int RES_W = 32;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One conversion result
  typedef struct packed {
    logic sinc3;
    logic [3:0] rate_code;
    logic [RES_W-1:0] value;
  } result_s;

  // Modulator clocks per result, the same for both filter types
  function automatic logic [OSR_W-1:0] osr_of(input logic [3:0] code);
    logic [OSR_W-1:0] r;
    r = 17'h00040;
    unique case (code)
      4'h0: r = 17'h19000;
      4'h1: r = 17'h0c800;
      4'h2: r = 17'h06400;
      4'h3: r = 17'h03c00;
      4'h4: r = 17'h03200;
      4'h5: r = 17'h01400;
      4'h6: r = 17'h010a8;
      4'h7: r = 17'h00a00;
      4'h8: r = 17'h00500;
      4'h9: r = 17'h00280;
      4'ha: r = 17'h00140;
      4'hb: r = 17'h00100;
      4'hc: r = 17'h00080;
      4'hd: r = 17'h00040;
      default: r = 17'h00040;
    endcase
    return r;
  endfunction : osr_of

endpackage : rate_filter_pkg

// file: src/rate_filter.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
// How it works
// - Config clock-select bit picks internal oscillator or external clock as system clock.
// - After power-up the internal oscillator is used until software selects external.
// - Pin reset or reset command returns clock selection to internal.
// - Modulator clock is selected system clock divided by sixteen.
// - One filter-type bit selects sinc3 or low-latency filter.
// - Modulator clocks per result depend on rate code only, not filter.
// - Rate codes 0000 to 0110 map to ratios 102400 down to 4264.
// - Rate codes 0111 to 1101 map to ratios 2560 down to 64.
// - Ratio equals modulator rate over output rate; nominal at 4.096 MHz.
// - Low-latency filter is an FIR giving a settled result each period.
// - Low-latency at 2.5, 5, 10, 20 SPS rejects both line frequencies.
// - Low-latency notches 50 Hz at 16.6 and 50 SPS, 60 Hz at 60 SPS.
// - Low-latency bandwidth rises with rate, 1.1 Hz up to 718 Hz.
// - Rate, conversion time and notches scale with the applied system clock.
// - Sinc3 output data carries three conversion cycles of latency.
module rate_filter (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // System clock ticks, one-cycle enables
  input wire logic int_osc_tick,
  input wire logic ext_clk_tick,
  // Modulator bitstream
  input wire logic mod_bit,
  output logic mod_clk_en,
  // Result stream to serial host side
  output rate_filter_pkg::result_s out_data,
  output logic out_valid,
  input wire logic out_ready,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int ACC_W = rate_filter_pkg::ACC_W;
  localparam int OSR_W = rate_filter_pkg::OSR_W;

  // Bus state
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next, w_strb0_reg, w_strb0_next;
  logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, soft_rst_reg, soft_rst_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [3:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [7:0] cfg_reg, cfg_next;

  // Clock state
  logic [3:0] div_reg, div_next;
  logic mod_en_reg, mod_en_next;

  // Filter state
  logic [ACC_W-1:0] i1_reg, i1_next, i2_reg, i2_next, i3_reg, i3_next;
  logic [ACC_W-1:0] d1_reg, d1_next, d2_reg, d2_next, d3_reg, d3_next;
  logic [OSR_W-1:0] ones_reg, ones_next, cnt_reg, cnt_next;
  logic [1:0] warm_reg, warm_next;
  logic pend_reg, pend_next;
  rate_filter_pkg::result_s pend_data_reg, pend_data_next, last_reg, last_next;
  logic [7:0] cfg_seen_reg, cfg_seen_next;

  // Buffer state
  rate_filter_pkg::result_s head_reg, head_next, spare_reg, spare_next;
  logic head_v_reg, head_v_next, spare_v_reg, spare_v_next;

  logic filt_rst, buf_in_ready, buf_push, sinc3_sel, clk_ext_sel;
  logic [3:0] rate_code;

  assign rate_code = cfg_reg[rate_filter_pkg::RATE_LSB +: 4];
  assign sinc3_sel = cfg_reg[rate_filter_pkg::FILTER_BIT];
  assign clk_ext_sel = cfg_reg[rate_filter_pkg::CLK_SEL_BIT];
  // Filter restarts on any reset or configuration change
  assign filt_rst = soft_rst_reg || (cfg_seen_reg != cfg_reg);
  assign buf_in_ready = !spare_v_reg;
  assign buf_push = pend_reg && buf_in_ready;

  // Register bus next state
  always_comb begin
    logic do_wr;
    logic do_rd;
    do_wr = 1'b0;
    do_rd = 1'b0;
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb0_next = w_strb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    cfg_next = cfg_reg;
    soft_rst_next = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Write once both halves are held
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      do_wr = 1'b1;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = rate_filter_pkg::RESP_OKAY;
      unique case (aw_addr_reg)
        rate_filter_pkg::RATE_CFG_OFFSET: begin
          if (w_strb0_reg) begin
            cfg_next = w_data_reg[7:0];
          end
        end
        rate_filter_pkg::CMD_OFFSET: begin
          if (w_strb0_reg && w_data_reg[rate_filter_pkg::CMD_RESET_BIT]) begin
            soft_rst_next = 1'b1;
          end
        end
        rate_filter_pkg::STATUS_OFFSET, rate_filter_pkg::RESULT_OFFSET: begin
          bresp_next = rate_filter_pkg::RESP_OKAY;
        end
        default: bresp_next = rate_filter_pkg::RESP_SLVERR;
      endcase
    end
    if (soft_rst_reg) begin
      cfg_next = rate_filter_pkg::RATE_CFG_RESET;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      do_rd = 1'b1;
      rvalid_next = 1'b1;
      rresp_next = rate_filter_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rate_filter_pkg::CMD_OFFSET: rdata_next = 32'h0000_0000;
        rate_filter_pkg::RATE_CFG_OFFSET: rdata_next = {24'h00_0000, cfg_reg};
        rate_filter_pkg::STATUS_OFFSET: begin
          rdata_next = {24'h00_0000, warm_reg, pend_reg, spare_v_reg, head_v_reg,
                        clk_ext_sel, sinc3_sel, mod_en_reg};
        end
        rate_filter_pkg::RESULT_OFFSET: rdata_next = last_reg.value;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = rate_filter_pkg::RESP_SLVERR;
        end
      endcase
    end
    // One transfer each way at a time
    awready_next = !aw_held_next && !bvalid_next && !do_wr;
    wready_next = !w_held_next && !bvalid_next && !do_wr;
    arready_next = !rvalid_next && !do_rd;
  end

  // Register bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      cfg_reg <= rate_filter_pkg::RATE_CFG_RESET;
      soft_rst_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb0_reg <= w_strb0_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      soft_rst_reg <= soft_rst_next;
    end
  end

  // Modulator clock divider
  always_comb begin
    logic sys_tick;
    sys_tick = clk_ext_sel ? ext_clk_tick : int_osc_tick;
    div_next = div_reg;
    mod_en_next = 1'b0;
    if (filt_rst) begin
      div_next = 4'h0;
    end else if (sys_tick) begin
      if (div_reg == 4'(rate_filter_pkg::MOD_DIV - 1)) begin
        div_next = 4'h0;
        mod_en_next = 1'b1;
      end else begin
        div_next = div_reg + 4'h1;
      end
    end
  end

  // Divider flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 4'h0;
      mod_en_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      mod_en_reg <= mod_en_next;
    end
  end

  // Decimation filters
  always_comb begin
    logic [ACC_W-1:0] x;
    logic [ACC_W-1:0] c1, c2, c3;
    logic [OSR_W-1:0] osr;
    x = {{(ACC_W-1){1'b0}}, mod_bit};
    osr = rate_filter_pkg::osr_of(rate_code);
    c1 = i3_reg - d1_reg;
    c2 = c1 - d2_reg;
    c3 = c2 - d3_reg;
    i1_next = i1_reg;
    i2_next = i2_reg;
    i3_next = i3_reg;
    d1_next = d1_reg;
    d2_next = d2_reg;
    d3_next = d3_reg;
    ones_next = ones_reg;
    cnt_next = cnt_reg;
    warm_next = warm_reg;
    pend_next = pend_reg && !buf_push;
    pend_data_next = pend_data_reg;
    last_next = last_reg;
    cfg_seen_next = cfg_reg;
    if (filt_rst) begin
      i1_next = '0;
      i2_next = '0;
      i3_next = '0;
      d1_next = '0;
      d2_next = '0;
      d3_next = '0;
      ones_next = '0;
      cnt_next = '0;
      warm_next = 2'h0;
      pend_next = 1'b0;
    end else if (mod_en_reg && !pend_reg) begin
      // both paths run, select picks output
      i1_next = i1_reg + x;
      i2_next = i2_reg + i1_reg + x;
      i3_next = i3_reg + i2_reg + i1_reg + x;
      ones_next = ones_reg + OSR_W'(mod_bit);
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg == osr - 1'b1) begin
        cnt_next = '0;
        ones_next = '0;
        d1_next = i3_reg;
        d2_next = c1;
        d3_next = c2;
        if (sinc3_sel) begin
          // hold off until three periods filled
          if (warm_reg == 2'(rate_filter_pkg::SINC3_WARMUP - 1)) begin
            pend_next = 1'b1;
          end else begin
            warm_next = warm_reg + 2'h1;
          end
          pend_data_next = {1'b1, rate_code, c3[ACC_W-1 -: rate_filter_pkg::RES_W]};
        end else begin
          pend_next = 1'b1;
          pend_data_next = {1'b0, rate_code,
                            {(rate_filter_pkg::RES_W-OSR_W){1'b0}}, ones_reg + OSR_W'(mod_bit)};
        end
      end
    end
    if (buf_push) begin
      last_next = pend_data_reg;
    end
  end

  // Filter flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
      ones_reg <= '0;
      cnt_reg <= '0;
      warm_reg <= 2'h0;
      pend_reg <= 1'b0;
      pend_data_reg <= '0;
      last_reg <= '0;
      cfg_seen_reg <= rate_filter_pkg::RATE_CFG_RESET;
    end else begin
      i1_reg <= i1_next;
      i2_reg <= i2_next;
      i3_reg <= i3_next;
      d1_reg <= d1_next;
      d2_reg <= d2_next;
      d3_reg <= d3_next;
      ones_reg <= ones_next;
      cnt_reg <= cnt_next;
      warm_reg <= warm_next;
      pend_reg <= pend_next;
      pend_data_reg <= pend_data_next;
      last_reg <= last_next;
      cfg_seen_reg <= cfg_seen_next;
    end
  end

  // Two-entry result buffer
  always_comb begin
    logic pop;
    pop = head_v_reg && out_ready;
    head_next = head_reg;
    spare_next = spare_reg;
    head_v_next = head_v_reg;
    spare_v_next = spare_v_reg;
    if (pop) begin
      if (spare_v_reg) begin
        head_next = spare_reg;
        spare_v_next = 1'b0;
      end else begin
        head_v_next = 1'b0;
      end
    end
    if (buf_push) begin
      if (!head_v_next) begin
        head_next = pend_data_reg;
        head_v_next = 1'b1;
      end else begin
        spare_next = pend_data_reg;
        spare_v_next = 1'b1;
      end
    end
  end

  // Buffer flops
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_reg) begin
      head_reg <= '0;
      spare_reg <= '0;
      head_v_reg <= 1'b0;
      spare_v_reg <= 1'b0;
    end else begin
      head_reg <= head_next;
      spare_reg <= spare_next;
      head_v_reg <= head_v_next;
      spare_v_reg <= spare_v_next;
    end
  end

  // Outputs straight from flops
  assign mod_clk_en = mod_en_reg;
  assign out_data = head_reg;
  assign out_valid = head_v_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule : rate_filter

// file: dv/rate_filter_monitor.sv
`timescale 1ns/1ns
module rate_filter_monitor (
  // Clock, ticks and result stream
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic int_osc_tick,
  input wire logic ext_clk_tick,
  input wire logic mod_clk_en,
  input wire rate_filter_pkg::result_s out_data,
  input wire logic out_valid,
  input wire logic out_ready,
  // Register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic take;
  logic [7:0] cfg_reg, cfg_next, quiet_reg, quiet_next;
  logic [5:0] tick_reg, tick_next;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Shadow config, selected ticks per modulator period, cycles since a write
  assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_comb begin
    cfg_next = cfg_reg;
    quiet_next = quiet_reg + {7'h00, quiet_reg != 8'hff};
    tick_next = (mod_clk_en ? 6'h00 : tick_reg) + {5'h00, cfg_reg[5] ? ext_clk_tick : int_osc_tick};
    if (take) begin
      quiet_next = 8'h00;
      if (s_axi_awaddr == rate_filter_pkg::RATE_CFG_OFFSET) cfg_next = s_axi_wdata[7:0];
      if (s_axi_awaddr == rate_filter_pkg::CMD_OFFSET && s_axi_wdata[0]) cfg_next = 8'h00;
    end
    if (!aresetn) begin
      cfg_next = rate_filter_pkg::RATE_CFG_RESET;
      quiet_next = 8'h00;
      tick_next = 6'h00;
    end
  end
  always_ff @(posedge aclk) begin
    cfg_reg <= cfg_next;
    quiet_reg <= quiet_next;
    tick_reg <= tick_next;
  end
  // Write steps: take, then response two edges later
  sequence s_wr_take;
    take;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write response not two cycles after take");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled result changed");
  a_mod_pulse: assert property (mod_clk_en |=> !mod_clk_en)
    else $error("modulator enable longer than one cycle");
  a_mod_divide: assert property (mod_clk_en && quiet_reg > 8'h96 |-> tick_reg == 6'h10)
    else $error("modulator period not sixteen selected ticks");
  a_result_tags: assert property ($rose(out_valid) && quiet_reg > 8'h08 |->
    out_data.sinc3 == cfg_reg[4] && out_data.rate_code == cfg_reg[3:0])
    else $error("result filter or rate tag differs from config");
endmodule : rate_filter_monitor

bind rate_filter rate_filter_monitor i_rate_filter_monitor (.aclk, .aresetn, .int_osc_tick,
  .ext_clk_tick, .mod_clk_en, .out_data, .out_valid, .out_ready, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// file: dv/mod_source.sv
`timescale 1ns/1ns
module mod_source (
  // Clock
  input wire logic aclk,
  // Modulator side
  input wire logic mod_clk_en,
  output logic int_osc_tick,
  output logic ext_clk_tick,
  output logic mod_bit,
  // Result side
  input wire logic stall,
  output logic out_ready
);
  logic [1:0] div_reg = 2'h0;
  logic ext_reg = 1'b0;
  logic bit_reg = 1'b0;
  // Free-running ticks: internal every third cycle, external every second
  // exact external clock
  always @(posedge aclk) begin
    div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    ext_reg <= !ext_reg;
  end
  // Bitstream flips after each sample, so a period holds half ones
  always @(posedge aclk) begin
    if (mod_clk_en) begin
      bit_reg <= !bit_reg;
    end
  end
  // Outputs; the sink takes results unless told to stall
  assign int_osc_tick = (div_reg == 2'h2);
  assign ext_clk_tick = ext_reg;
  assign mod_bit = bit_reg;
  assign out_ready = !stall;
endmodule : mod_source

// file: dv/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic stall = 1'b0;
  logic int_osc_tick, ext_clk_tick, mod_bit, mod_clk_en, out_valid, out_ready;
  rate_filter_pkg::result_s out_data;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int mismatches = 0;
  int num_checks = 0;
  int ticks = 0;
  typedef struct {logic [7:0] cfg; int osr; int per;} row_s;
  // Config, modulator clocks per result, cycles per modulator clock
  // listed rate codes only
  row_s rows [5] = '{'{8'h0d, 64, 48}, '{8'h2d, 64, 32}, '{8'h2c, 128, 32},
    '{8'h2b, 256, 32}, '{8'h3d, 64, 32}};
  // Clock and modulator tick count
  always #25 aclk = !aclk;
  always @(posedge aclk) begin
    if (mod_clk_en === 1'b1) ticks <= ticks + 1;
  end
  rate_filter i_rate_filter (.aclk, .aresetn, .int_osc_tick, .ext_clk_tick, .mod_bit,
    .mod_clk_en, .out_data, .out_valid, .out_ready, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mod_source i_mod_source (.aclk, .mod_clk_en, .int_osc_tick, .ext_clk_tick, .mod_bit, .stall,
    .out_ready);
  // Bus write: address and data together, response awaited
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", rate_filter_pkg::RESP_OKAY, s_axi_bresp)
  endtask : wr
  // Bus read
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
    input logic [1:0] er = rate_filter_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, s_axi_rresp)
  endtask : rd
  // Next result taken by the sink, with cycles waited
  task automatic get_res(output rate_filter_pkg::result_s r, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (out_valid !== 1'b1 && n < 40000);
    r = out_data;
    if (n >= 40000) mismatches++;
  endtask : get_res
  // Cycles between two modulator enables
  task automatic mod_per(output int c);
    c = 0;
    do @(posedge aclk); while (mod_clk_en !== 1'b1 && c++ < 500);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (mod_clk_en !== 1'b1 && c < 500);
  endtask : mod_per
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    logic [31:0] d;
    rate_filter_pkg::result_s r;
    int n, c, t0, t1, k;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(rate_filter_pkg::RATE_CFG_OFFSET, d);
    `CHK("cfg", {24'h000000, rate_filter_pkg::RATE_CFG_RESET}, d)
    mod_per(c);
    `CHK("period", 48, c)
    $display("test reset done");
    foreach (rows[i]) begin
      t0 = ticks;
      wr(rate_filter_pkg::RATE_CFG_OFFSET, rows[i].cfg);
      get_res(r, n);
      k = rows[i].cfg[4] ? 3 : 1;
      `CHK("latency", 1'b1, (ticks - t0 - k * rows[i].osr) inside {[-2:2]})
      t1 = ticks;
      rd(rate_filter_pkg::RATE_CFG_OFFSET, d);
      `CHK("cfg", rows[i].cfg, d[7:0])
      rd(rate_filter_pkg::STATUS_OFFSET, d);
      `CHK("status", rows[i].cfg[5:4], {d[2], d[1]})
      mod_per(c);
      `CHK("period", rows[i].per, c)
      get_res(r, n);
      `CHK("osr", rows[i].osr, ticks - t1)
      `CHK("tags", rows[i].cfg[4:0], {r.sinc3, r.rate_code})
      if (!rows[i].cfg[4]) `CHK("value", rows[i].osr / 2, r.value)
      $display("test rate row %0d done", i);
    end
    wr(rate_filter_pkg::CMD_OFFSET, 8'h01);
    repeat (2) @(posedge aclk);
    rd(rate_filter_pkg::RATE_CFG_OFFSET, d);
    `CHK("cfg", 32'h00000000, d)
    mod_per(c);
    `CHK("period", 48, c)
    wr(rate_filter_pkg::RATE_CFG_OFFSET, 8'h20);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(rate_filter_pkg::RATE_CFG_OFFSET, d);
    `CHK("cfg", 32'h00000000, d)
    $display("test reset command and pin done");
    wr(rate_filter_pkg::RATE_CFG_OFFSET, 8'h2d);
    stall <= 1'b1;
    repeat (6400) @(posedge aclk);
    rd(rate_filter_pkg::STATUS_OFFSET, d);
    `CHK("full", 2'h3, d[4:3])
    `CHK("out_valid", 1'b1, out_valid)
    stall <= 1'b0;
    get_res(r, n);
    `CHK("head", 32'h00000020, r.value)
    get_res(r, n);
    `CHK("spare", 32'h00000020, r.value)
    `CHK("gap", 1, n)
    rd(rate_filter_pkg::RESULT_OFFSET, d);
    `CHK("result", 32'h00000020, d)
    rd(4'h2, d, rate_filter_pkg::RESP_SLVERR);
    `CHK("unmapped", 32'h00000000, d)
    $display("test buffer stall done");
    final_report();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge aclk);
    mismatches++;
    final_report();
  end
endmodule : tb
